/* File: shared/cycle_pkg.sv */
// Function
// - Upper/lower thresholds are level plus/minus hysteresis
// - Every sample classed above, within or below
// - Below to above is rising, interpolated
// - Above to below is falling; return gives none
// - Detect live, calculations lag by fixed delay
// - Too-late crossing rejected, next good edge ends
// - Unselected direction never ends a period
// - First good edge after rejects signals within-range
// - Over-long band stay reports no crossing
// - Low amplitude event stamped at band entry
// - Repeat low slew raises no extra events
// - Quiet recovery interval raises end event
// - Too many state changes means overload
// - Overload event raised, current period aborted
// - Quiet recovery ends overload, new period starts
// - Overload events suppressed for one interval
// - Too fast signals event, periods extended
// - Half mode passes all, full counts cycles
// - No selected edge within timeout aborts period
// - No new period before minimum interval
`default_nettype none
package cycle_pkg;
  localparam int DATA_W = 16;
  localparam int TS_W = 32;
  localparam int FRAC_W = 4;
  localparam int XW = TS_W + FRAC_W;
  localparam int CNT_W = 24;
  localparam int NCYC_W = 8;

  // Sample rate of the internal time base; all timing is counted in samples
  localparam int SAMPLE_HZ = 100000;
  localparam int DELAY_MS = 10;
  localparam int DELAY_SMP = DELAY_MS * SAMPLE_HZ / 1000;
  localparam int SLEW_MS = 20;
  localparam int SLEW_SMP = SLEW_MS * SAMPLE_HZ / 1000;
  localparam int RECOVER_S = 1;
  localparam int RECOVER_SMP = RECOVER_S * SAMPLE_HZ;
  localparam int SUPPRESS_S = 1;
  localparam int SUPPRESS_SMP = SUPPRESS_S * SAMPLE_HZ;
  localparam int TIMEOUT_S = 1;
  localparam int TIMEOUT_SMP = TIMEOUT_S * SAMPLE_HZ;
  localparam int MIN_PERIOD_US = 900;
  localparam int MIN_PERIOD_SMP = (MIN_PERIOD_US * SAMPLE_HZ + 999999) / 1000000;
  localparam int MAX_CHANGES_PER_S = 80000;
  localparam int WIN_MS = 10;
  localparam int WIN_SMP = WIN_MS * SAMPLE_HZ / 1000;
  localparam int WIN_CHANGES = MAX_CHANGES_PER_S * WIN_MS / 1000;

  // Register offsets
  localparam logic [3:0] OFS_LEVEL = 4'h0;
  localparam logic [3:0] OFS_HYST = 4'h4;
  localparam logic [3:0] OFS_CTRL = 4'h8;
  localparam logic [3:0] OFS_STATUS = 4'hc;
  localparam int CTRL_DIR_BIT = 0;
  localparam int CTRL_HALF_BIT = 1;
  localparam int CTRL_NCYC_LSB = 8;
  localparam logic [DATA_W-1:0] LEVEL_RST = 16'h0000;
  localparam logic [DATA_W-1:0] HYST_RST = 16'h0100;
  localparam logic DIR_RST = 1'b1;
  localparam logic HALF_RST = 1'b0;
  localparam logic [NCYC_W-1:0] NCYC_RST = 8'h01;

  // Event type codes
  localparam logic [3:0] EV_NONE = 4'h0;
  localparam logic [3:0] EV_LOW_AMP = 4'h1;
  localparam logic [3:0] EV_AMP_OK = 4'h2;
  localparam logic [3:0] EV_WITHIN = 4'h3;
  localparam logic [3:0] EV_NO_CYCLES = 4'h4;
  localparam logic [3:0] EV_OVERLOAD = 4'h5;
  localparam logic [3:0] EV_FREQ_HIGH = 4'h6;

  // Code 2'b10 is never produced
  typedef enum logic [1:0] {
    BAND_BELOW = 2'b00,
    BAND_WITHIN = 2'b01,
    BAND_ABOVE = 2'b11
  } band_e;

  // Place a sample against the hysteresis band
  function automatic band_e classify(input logic signed [DATA_W-1:0] smp,
                                     input logic signed [DATA_W-1:0] lvl,
                                     input logic [DATA_W-1:0] hys);
    logic signed [DATA_W+1:0] x;
    logic signed [DATA_W+1:0] up;
    logic signed [DATA_W+1:0] lo;
    x = (DATA_W+2)'(smp);
    up = (DATA_W+2)'(lvl) + $signed({2'b00, hys});
    lo = (DATA_W+2)'(lvl) - $signed({2'b00, hys});
    if (x > up) begin
      classify = BAND_ABOVE;
    end else if (x < lo) begin
      classify = BAND_BELOW;
    end else begin
      classify = BAND_WITHIN;
    end
  endfunction

  // Distance between two stamps is at least lim (wraps safely)
  function automatic logic span_ge(input logic [XW-1:0] later, input logic [XW-1:0] earlier,
                                   input logic [XW-1:0] lim);
    logic [XW-1:0] d;
    d = later - earlier;
    span_ge = d >= lim;
  endfunction
endpackage
`default_nettype wire

/* File: rtl/crossing_interp.sv */
`timescale 1ns/10ps
`default_nettype none
module crossing_interp
  import cycle_pkg::*;
#(
  parameter int DW = DATA_W,
  parameter int TW = TS_W,
  parameter int FW = FRAC_W
) (
  input wire logic [TW-1:0] t1,
  input wire logic signed [DW-1:0] v1,
  input wire logic [TW-1:0] t2,
  input wire logic signed [DW-1:0] v2,
  input wire logic signed [DW-1:0] level,
  output logic [TW+FW-1:0] cross_ts
);
  localparam int PW = DW + 1 + TW + FW;
  logic signed [DW:0] num;
  logic signed [DW:0] den;
  logic [DW:0] num_mag;
  logic [DW:0] den_mag;
  logic [TW-1:0] dt;
  logic [PW-1:0] prod;
  logic [PW-1:0] quot;

  function automatic logic [DW:0] mag(input logic signed [DW:0] x);
    mag = x[DW] ? (DW+1)'(-x) : (DW+1)'(x);
  endfunction

  // Straight line between the two samples that bracket the band;
  // the divider is combinational, so it must settle within one sys_clk cycle
  always_comb begin
    num = (DW+1)'(level) - (DW+1)'(v1);
    den = (DW+1)'(v2) - (DW+1)'(v1);
    num_mag = mag(num);
    den_mag = mag(den);
    dt = t2 - t1;
    prod = (PW'(num_mag) * PW'(dt)) << FW;
    quot = (den_mag == '0) ? '0 : prod / PW'(den_mag);
    cross_ts = {t1, FW'(0)} + (TW+FW)'(quot);
  end
endmodule
`default_nettype wire

/* File: rtl/cycle_level_crossing_detector.sv */
// The plain strobed port and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module cycle_level_crossing_detector
  import cycle_pkg::*;
#(
  parameter int DELAY_CNT = DELAY_SMP,
  parameter int SLEW_CNT = SLEW_SMP,
  parameter int RECOVER_CNT = RECOVER_SMP,
  parameter int SUPPRESS_CNT = SUPPRESS_SMP,
  parameter int TIMEOUT_CNT = TIMEOUT_SMP,
  parameter int MIN_PERIOD_CNT = MIN_PERIOD_SMP,
  parameter int WIN_CNT = WIN_SMP,
  parameter int WIN_LIMIT = WIN_CHANGES
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic [3:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  input wire logic sample_valid,
  input wire logic signed [DATA_W-1:0] sample_data,
  output logic cross_valid,
  output logic cross_rising,
  output logic [XW-1:0] cross_ts,
  output logic period_end,
  output logic period_start,
  output logic period_abort,
  output logic [XW-1:0] period_ts,
  output logic event_valid,
  output logic [3:0] event_code,
  output logic [XW-1:0] event_ts
);
  typedef struct packed {
    logic signed [DATA_W-1:0] level;
    logic [DATA_W-1:0] hyst;
    logic dir_rising;
    logic half_mode;
    logic [NCYC_W-1:0] ncyc;
    logic [31:0] rdata;
    band_e band;
    band_e side;
    logic side_valid;
    logic [TS_W-1:0] now;
    logic [TS_W-1:0] last_ts;
    logic signed [DATA_W-1:0] last_val;
    logic [TS_W-1:0] enter_ts;
    logic [CNT_W-1:0] band_cnt;
    logic long_exc;
    logic slew_act;
    logic [CNT_W-1:0] slew_quiet;
    logic [TS_W-1:0] slew_end_ts;
    logic rej;
    logic [XW-1:0] rej_ts;
    logic [CNT_W-1:0] win_cnt;
    logic [CNT_W-1:0] chg_cnt;
    logic ovl;
    logic [CNT_W-1:0] ovl_quiet;
    logic [CNT_W-1:0] supp_cnt;
    logic open;
    logic [XW-1:0] start_ts;
    logic [NCYC_W-1:0] cyc_cnt;
    logic [CNT_W-1:0] edge_age;
    logic [XW-1:0] edge_ts;
    logic nocyc;
    logic fhigh;
    logic ext;
    logic cross_valid;
    logic cross_rising;
    logic [XW-1:0] cross_ts;
    logic period_end;
    logic period_start;
    logic period_abort;
    logic [XW-1:0] period_ts;
    logic event_valid;
    logic [3:0] event_code;
    logic [XW-1:0] event_ts;
  } state_s;

  state_s s;
  state_s n;
  band_e c;
  logic [XW-1:0] x_ts;
  logic [XW-1:0] now_x;
  logic [NCYC_W-1:0] cyc_nxt;
  logic xing;
  logic rising;
  logic late;
  logic sel;
  logic fire;
  logic chg;
  logic detect;
  logic [3:0] ev_c;
  logic [XW-1:0] ev_t;

  ////////////////////////////////////////////////////////////////////////////
  // Interpolation between the last sample of the old side and this sample
  crossing_interp u_interp (
    .t1(s.last_ts),
    .v1(s.last_val),
    .t2(s.now),
    .v2(sample_data),
    .level(s.level),
    .cross_ts(x_ts)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next state; only one event leaves per sample, later ones in the
  // code take precedence because they matter more downstream
  always_comb begin
    n = s;
    c = BAND_WITHIN;
    now_x = {s.now, FRAC_W'(0)};
    cyc_nxt = s.cyc_cnt + 1'b1;
    xing = 1'b0;
    rising = 1'b0;
    late = 1'b0;
    sel = 1'b0;
    fire = 1'b0;
    chg = 1'b0;
    detect = 1'b0;
    ev_c = EV_NONE;
    ev_t = '0;
    n.cross_valid = 1'b0;
    n.period_end = 1'b0;
    n.period_start = 1'b0;
    n.period_abort = 1'b0;
    n.event_valid = 1'b0;
    n.rdata = '0;

    // Register writes
    if (wr) begin
      case (addr)
        OFS_LEVEL: n.level = wdata[DATA_W-1:0];
        OFS_HYST: n.hyst = wdata[DATA_W-1:0];
        OFS_CTRL: begin
          n.dir_rising = wdata[CTRL_DIR_BIT];
          n.half_mode = wdata[CTRL_HALF_BIT];
          n.ncyc = wdata[CTRL_NCYC_LSB +: NCYC_W];
        end
        default: ;
      endcase
    end

    // Register reads, data stands for the following cycle only
    if (rd) begin
      case (addr)
        OFS_LEVEL: n.rdata = 32'(unsigned'(s.level));
        OFS_HYST: n.rdata = 32'(s.hyst);
        OFS_CTRL: n.rdata = 32'({s.ncyc, 6'h00, s.half_mode, s.dir_rising});
        OFS_STATUS: n.rdata = 32'({s.fhigh, s.nocyc, s.ovl, s.slew_act, s.open, s.band});
        default: n.rdata = '0;
      endcase
    end

    if (sample_valid) begin
      c = classify(sample_data, s.level, s.hyst);
      n.now = s.now + 1'b1;
      n.band = c;

      // State change rate over back-to-back fixed blocks of samples
      chg = c != s.band;
      n.win_cnt = s.win_cnt + 1'b1;
      n.chg_cnt = s.chg_cnt + CNT_W'(chg);
      if (s.win_cnt >= CNT_W'(WIN_CNT - 1)) begin
        detect = n.chg_cnt > CNT_W'(WIN_LIMIT);
        n.win_cnt = '0;
        n.chg_cnt = '0;
      end
      if (s.supp_cnt != '0) begin
        n.supp_cnt = s.supp_cnt - 1'b1;
      end

      // Band stay timing and side tracking
      if (c == BAND_WITHIN) begin
        if (s.band != BAND_WITHIN) begin
          n.enter_ts = s.now;
          n.band_cnt = CNT_W'(1);
          n.long_exc = 1'b0;
        end else if (!s.long_exc) begin
          n.band_cnt = s.band_cnt + 1'b1;
        end
        if (!n.long_exc && n.band_cnt > CNT_W'(SLEW_CNT)) begin
          n.long_exc = 1'b1;
          if (!s.slew_act) begin
            ev_c = EV_LOW_AMP;
            ev_t = {n.enter_ts, FRAC_W'(0)};
            n.slew_act = 1'b1;
          end
        end
      end else begin
        if (s.long_exc) begin
          n.slew_end_ts = s.now;
          n.long_exc = 1'b0;
        end
        // Return to the starting side gives no crossing
        xing = s.side_valid && (c != s.side);
        rising = c == BAND_ABOVE;
        n.side = c;
        n.side_valid = 1'b1;
        n.last_ts = s.now;
        n.last_val = sample_data;
      end

      // Recovery from low slew is counted only while no long stay runs
      if (n.long_exc) begin
        n.slew_quiet = '0;
      end else if (s.slew_quiet < CNT_W'(RECOVER_CNT)) begin
        n.slew_quiet = s.slew_quiet + 1'b1;
      end
      if (s.slew_act && !n.long_exc && s.slew_quiet >= CNT_W'(RECOVER_CNT)) begin
        ev_c = EV_AMP_OK;
        ev_t = {s.slew_end_ts, FRAC_W'(0)};
        n.slew_act = 1'b0;
      end

      // Crossing acceptance; samples behind the delay are already consumed
      if (xing && !s.ovl) begin
        late = s.long_exc || span_ge(now_x, x_ts, XW'((DELAY_CNT << FRAC_W) + 1));
        if (late) begin
          n.rej = 1'b1;
          n.rej_ts = x_ts;
        end else begin
          n.cross_valid = 1'b1;
          n.cross_rising = rising;
          n.cross_ts = x_ts;
          sel = s.half_mode || (rising == s.dir_rising);
        end
      end

      // Counter/filter
      if (sel) begin
        n.edge_age = '0;
        n.edge_ts = x_ts;
        fire = !s.open || s.half_mode || (cyc_nxt >= s.ncyc);
        n.cyc_cnt = fire ? '0 : cyc_nxt;
      end

      if (fire) begin
        if (s.rej) begin
          ev_c = EV_WITHIN;
          ev_t = s.rej_ts + XW'(1);
          n.rej = 1'b0;
        end
        if (!s.open) begin
          if (s.nocyc) begin
            ev_c = EV_WITHIN;
            ev_t = x_ts;
          end
          n.nocyc = 1'b0;
          n.open = 1'b1;
          n.start_ts = x_ts;
          n.period_start = 1'b1;
          n.period_ts = x_ts;
          n.ext = 1'b0;
        end else if (!span_ge(x_ts, s.start_ts, XW'(MIN_PERIOD_CNT << FRAC_W))) begin
          // Too soon: hold the count so the next selected edge retries
          n.cyc_cnt = s.cyc_cnt;
          n.ext = 1'b1;
          if (!s.fhigh) begin
            ev_c = EV_FREQ_HIGH;
            ev_t = x_ts;
          end
          n.fhigh = 1'b1;
        end else begin
          n.period_end = 1'b1;
          n.period_ts = x_ts;
          n.start_ts = x_ts;
          n.ext = 1'b0;
          if (s.fhigh && !s.ext) begin
            ev_c = EV_WITHIN;
            ev_t = x_ts;
            n.fhigh = 1'b0;
          end
        end
      end else if (s.open && !sel) begin
        n.edge_age = s.edge_age + 1'b1;
        if (s.edge_age >= CNT_W'(TIMEOUT_CNT - 1)) begin
          ev_c = EV_NO_CYCLES;
          ev_t = s.edge_ts;
          n.open = 1'b0;
          n.nocyc = 1'b1;
          n.period_abort = 1'b1;
          n.period_ts = now_x;
        end
      end

      // Overload and its recovery
      if (detect) begin
        n.ovl = 1'b1;
        n.ovl_quiet = '0;
        if (s.supp_cnt == '0) begin
          ev_c = EV_OVERLOAD;
          ev_t = now_x;
          n.supp_cnt = CNT_W'(SUPPRESS_CNT);
        end
        if (n.open) begin
          n.open = 1'b0;
          n.period_abort = 1'b1;
          n.period_end = 1'b0;
          n.period_start = 1'b0;
          n.period_ts = now_x;
        end
      end else if (s.ovl) begin
        n.ovl_quiet = s.ovl_quiet + 1'b1;
        if (s.ovl_quiet >= CNT_W'(RECOVER_CNT - 1)) begin
          ev_c = EV_WITHIN;
          ev_t = now_x;
          n.ovl = 1'b0;
          n.open = 1'b1;
          n.nocyc = 1'b0;
          n.start_ts = now_x;
          n.edge_ts = now_x;
          n.edge_age = '0;
          n.cyc_cnt = '0;
          n.period_start = 1'b1;
          n.period_ts = now_x;
        end
      end

      if (ev_c != EV_NONE) begin
        n.event_valid = 1'b1;
        n.event_code = ev_c;
        n.event_ts = ev_t;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register; ce low freezes everything including pulses
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      s <= '0;
      s.level <= LEVEL_RST;
      s.hyst <= HYST_RST;
      s.dir_rising <= DIR_RST;
      s.half_mode <= HALF_RST;
      s.ncyc <= NCYC_RST;
      s.band <= BAND_WITHIN;
      s.side <= BAND_WITHIN;
    end else if (ce) begin
      s <= n;
    end
  end

  assign rdata = s.rdata;
  assign cross_valid = s.cross_valid;
  assign cross_rising = s.cross_rising;
  assign cross_ts = s.cross_ts;
  assign period_end = s.period_end;
  assign period_start = s.period_start;
  assign period_abort = s.period_abort;
  assign period_ts = s.period_ts;
  assign event_valid = s.event_valid;
  assign event_code = s.event_code;
  assign event_ts = s.event_ts;
endmodule
`default_nettype wire

/* File: testbench/sample_source.sv */
`timescale 1ns/10ps
`default_nettype none
module sample_source
  import cycle_pkg::*;
(
  input wire logic sys_clk,
  output logic sample_valid,
  output logic signed [DATA_W-1:0] sample_data
);
  ////////////////////////////////////////////////////////////
  // Idle data shows the inverse of the last value, so a stale read cannot pass
  initial begin
    sample_valid = 1'b0;
    sample_data = 16'sh5a5a;
  end

  // One sample per call; the strobe drops for a cycle between calls
  task automatic put(input logic signed [DATA_W-1:0] v);
    @(posedge sys_clk);
    sample_valid <= 1'b1;
    sample_data <= v;
    @(posedge sys_clk);
    sample_valid <= 1'b0;
    sample_data <= ~v;
  endtask
endmodule
`default_nettype wire

/* File: testbench/cycle_level_crossing_detector_monitor.sv */
`timescale 1ns/10ps
`default_nettype none
module cycle_level_crossing_detector_monitor
  import cycle_pkg::*;
#(
  parameter int DELAY_CNT = DELAY_SMP,
  parameter int MIN_PERIOD_CNT = MIN_PERIOD_SMP,
  parameter int SUPPRESS_CNT = SUPPRESS_SMP
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic [3:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [31:0] rdata,
  input wire logic sample_valid,
  input wire logic signed [DATA_W-1:0] sample_data,
  input wire logic cross_valid,
  input wire logic cross_rising,
  input wire logic [XW-1:0] cross_ts,
  input wire logic period_end,
  input wire logic period_start,
  input wire logic period_abort,
  input wire logic [XW-1:0] period_ts,
  input wire logic event_valid,
  input wire logic [3:0] event_code,
  input wire logic [XW-1:0] event_ts
);
  localparam logic [XW-1:0] LATE_LIM = XW'(DELAY_CNT * 16);
  localparam logic [XW-1:0] MIN_LIM = XW'(MIN_PERIOD_CNT * 16);
  logic [TS_W-1:0] nsmp;
  logic [XW-1:0] last_pts;
  logic [XW-1:0] cur_ts;
  int ovl_gap;
  logic la_open;

  ////////////////////////////////////////////////////////////
  // Stamp of the sample that caused this cycle's outputs
  assign cur_ts = {nsmp - 1'b1, 4'h0};

  // Sample count, last period stamp, overload spacing, open low-amplitude condition
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      nsmp <= '0;
      last_pts <= '0;
      ovl_gap <= SUPPRESS_CNT;
      la_open <= 1'b0;
    end else begin
      if (sample_valid && ce) nsmp <= nsmp + 1'b1;
      if (period_end || period_start) last_pts <= period_ts;
      if (event_valid && event_code == EV_OVERLOAD) ovl_gap <= 0;
      else if (sample_valid && ovl_gap < SUPPRESS_CNT) ovl_gap <= ovl_gap + 1;
      if (event_valid && event_code == EV_LOW_AMP) la_open <= 1'b1;
      else if (event_valid && event_code == EV_AMP_OK) la_open <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  property p_cross_on_sample; cross_valid |-> $past(sample_valid); endproperty
  property p_event_on_sample; event_valid |-> $past(sample_valid, 1); endproperty
  property p_event_code; event_valid |-> event_code inside {[EV_LOW_AMP:EV_FREQ_HIGH]}; endproperty
  property p_cross_not_future; cross_valid |-> cross_ts <= cur_ts; endproperty
  property p_cross_not_late; cross_valid |-> (cur_ts - cross_ts) <= LATE_LIM; endproperty
  property p_period_min; period_end |-> (period_ts - last_pts) >= MIN_LIM; endproperty
  property p_end_on_cross; period_end |-> cross_valid && cross_ts == period_ts; endproperty
  property p_end_gap; period_end |=> !period_end [*4]; endproperty
  property p_status; rd && addr == OFS_STATUS |=> rdata[1:0] != 2'b10 && rdata[31:7] == '0;
  endproperty
  property p_ovl_gap; event_valid && event_code == EV_OVERLOAD |-> ovl_gap >= SUPPRESS_CNT - 1;
  endproperty
  property p_low_once; event_valid && event_code == EV_LOW_AMP |-> !la_open; endproperty

  a_cross_on_sample: assert property (p_cross_on_sample)
    else $error("crossing without a sample");
  a_event_on_sample: assert property (p_event_on_sample)
    else $error("event without a sample");
  a_event_code: assert property (p_event_code)
    else $error("event code out of range");
  a_cross_not_future: assert property (p_cross_not_future)
    else $error("crossing stamped after its sample");
  a_cross_not_late: assert property (p_cross_not_late)
    else $error("late crossing accepted");
  a_period_min: assert property (p_period_min)
    else $error("period shorter than minimum");
  a_end_on_cross: assert property (p_end_on_cross)
    else $error("period end without matching crossing");
  a_end_gap: assert property (p_end_gap)
    else $error("period ends too close together");
  a_status: assert property (p_status)
    else $error("status band code invalid");
  a_ovl_gap: assert property (p_ovl_gap)
    else $error("overload event not suppressed");
  a_low_once: assert property (p_low_once)
    else $error("repeated low amplitude event");

  // Main scenarios reached
  c_end: cover property (period_end);
  c_ovl: cover property (event_valid && event_code == EV_OVERLOAD);
  c_low: cover property (event_valid && event_code == EV_LOW_AMP);
endmodule

bind cycle_level_crossing_detector cycle_level_crossing_detector_monitor #(
  .DELAY_CNT(DELAY_CNT),
  .MIN_PERIOD_CNT(MIN_PERIOD_CNT),
  .SUPPRESS_CNT(SUPPRESS_CNT)
) cycle_level_crossing_detector_monitor_i (.sys_clk, .rstn, .ce, .addr, .wdata, .wr, .rd,
  .rdata, .sample_valid, .sample_data, .cross_valid, .cross_rising, .cross_ts, .period_end,
  .period_start, .period_abort, .period_ts, .event_valid, .event_code, .event_ts);
`default_nettype wire

/* File: testbench/cycle_level_crossing_detector_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module cycle_level_crossing_detector_tb;
  import cycle_pkg::*;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic ce = 1'b1;
  logic [31:0] rdata;
  logic sample_valid;
  logic signed [DATA_W-1:0] sample_data;
  logic cross_valid, cross_rising, period_end, period_start, period_abort, event_valid, c_rise;
  logic [XW-1:0] cross_ts, period_ts, event_ts, c_ts, p_ts;
  logic [XW-1:0] ev_ts [16];
  logic [3:0] event_code;
  int n_mismatch, checked, n_cross, n_end, n_start, n_abort, k, e, s, a;
  int ev_cnt [16];
  logic signed [15:0] bv [5] = '{-16'sh101, 16'sh100, 16'sh101, -16'sh100, -16'sh101};
  logic [1:0] bb [5] = '{2'b00, 2'b01, 2'b11, 2'b01, 2'b00};

  always #12.5 sys_clk = ~sys_clk;

  // Short counts keep the run small; expectations below follow these values.
  // The window is wide enough that the opening band sweep stays under the change limit
  localparam int DLY = 10, SLW = 20, REC = 200, MINP = 5, WN = 20, LIM = 15;
  cycle_level_crossing_detector #(.DELAY_CNT(DLY), .SLEW_CNT(SLW), .RECOVER_CNT(REC),
    .SUPPRESS_CNT(REC), .TIMEOUT_CNT(REC), .MIN_PERIOD_CNT(MINP), .WIN_CNT(WN), .WIN_LIMIT(LIM))
  cycle_level_crossing_detector_i (.sys_clk, .rstn, .ce, .addr, .wdata, .wr, .rd, .rdata,
    .sample_valid, .sample_data, .cross_valid, .cross_rising, .cross_ts, .period_end,
    .period_start, .period_abort, .period_ts, .event_valid, .event_code, .event_ts);

  sample_source sample_source_i (.sys_clk, .sample_valid, .sample_data);

  ////////////////////////////////////////////////////////////
  // Collect pulses; values read here are those registered one edge earlier
  always @(posedge sys_clk) begin
    if (rstn) begin
      if (cross_valid) begin
        n_cross++;
        c_ts = cross_ts;
        c_rise = cross_rising;
      end
      if (period_end || period_start) p_ts = period_ts;
      if (period_end) n_end++;
      if (period_start) n_start++;
      if (period_abort) n_abort++;
      if (event_valid) begin
        ev_cnt[event_code]++;
        ev_ts[event_code] = event_ts;
      end
    end
  end

  task automatic chk(input string what, input logic [XW-1:0] exp, input logic [XW-1:0] got);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic wr_reg(input logic [3:0] ad, input logic [31:0] d);
    @(posedge sys_clk);
    addr <= ad;
    wdata <= d;
    wr <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd_chk(input string what, input logic [3:0] ad, input logic [31:0] exp,
                        input logic [31:0] mask);
    @(posedge sys_clk);
    addr <= ad;
    rd <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    @(posedge sys_clk);
    chk(what, XW'(exp), XW'(rdata & mask));
  endtask

  task automatic smp(input logic signed [DATA_W-1:0] v, input int n);
    repeat (n) sample_source_i.put(v);
    repeat (3) @(posedge sys_clk);
  endtask

  task automatic fin(input string name);
    $display("test %s done", name);
  endtask

  task automatic results;
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Hang guard, well beyond the roughly 1300 cycles the sequence needs
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_mismatch++;
    results();
  end

  ////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge sys_clk);
    rstn <= 1'b1;
    rd_chk("level rst", OFS_LEVEL, {16'h0, LEVEL_RST}, '1);
    rd_chk("hyst rst", OFS_HYST, {16'h0, HYST_RST}, '1);
    rd_chk("ctrl rst", OFS_CTRL, 32'h0000_0101, '1);
    // A write while the enable is low must leave the register alone
    ce <= 1'b0;
    wr_reg(OFS_HYST, 32'h0000_0055);
    ce <= 1'b1;
    rd_chk("ce freeze", OFS_HYST, {16'h0, HYST_RST}, '1);
    wr_reg(4'h2, 32'h0000_5555);
    rd_chk("unmapped", 4'h2, 32'h0, '1);
    wr_reg(OFS_LEVEL, 32'h0000_1234);
    rd_chk("level wr", OFS_LEVEL, 32'h0000_1234, '1);
    wr_reg(OFS_LEVEL, 32'h0);
    wr_reg(OFS_CTRL, 32'h0000_0302);
    rd_chk("ctrl wr", OFS_CTRL, 32'h0000_0302, '1);
    wr_reg(OFS_CTRL, 32'h0000_0101);
    wr_reg(OFS_STATUS, 32'hffff_ffff);
    fin("registers");
    // Threshold edges: level plus or minus hysteresis still counts as within
    for (int i = 0; i < 5; i++) begin
      smp(bv[i], 1);
      rd_chk("band", OFS_STATUS, 32'(bb[i]), 32'h3);
    end
    chk("first start", 1, n_start);
    chk("rise ts", 16, p_ts);
    chk("fall ts", 48, c_ts);
    chk("fall dir", 0, c_rise);
    chk("no end on fall", 0, n_end);
    smp(16'sh0, 1);
    smp(-16'sh200, 1);
    chk("return", 2, n_cross);
    smp(16'sh200, 1);
    chk("end", 1, n_end);
    chk("end ts", 104, p_ts);
    fin("crossings");
    // Rising edge too soon after the period start is passed over
    smp(-16'sh200, 1);
    smp(16'sh200, 1);
    chk("too soon", 1, n_end);
    chk("freq high", 1, ev_cnt[EV_FREQ_HIGH]);
    smp(16'sh200, 2);
    smp(-16'sh200, 1);
    smp(16'sh200, 1);
    chk("ext ts", 200, p_ts);
    fin("rate limit");
    // Slow rise found too late, then a clean edge ends the period
    k = n_cross;
    e = ev_cnt[EV_WITHIN];
    smp(-16'sh101, 1);
    smp(-16'sh100, 15);
    smp(16'sh7fff, 1);
    chk("late cross", k + 1, n_cross);
    chk("late end", 2, n_end);
    smp(-16'sh200, 1);
    smp(16'sh200, 1);
    chk("within", e + 1, ev_cnt[EV_WITHIN]);
    chk("after late", 504, p_ts);
    fin("late");
    // Long stay in the band, twice
    k = n_cross;
    smp(-16'sh200, 1);
    smp(16'sh0, 25);
    smp(16'sh200, 1);
    chk("slew cross", k + 1, n_cross);
    chk("low amp", 1, ev_cnt[EV_LOW_AMP]);
    chk("low amp ts", 34 * 16, ev_ts[EV_LOW_AMP]);
    smp(-16'sh200, 1);
    smp(16'sh200, 1);
    smp(-16'sh200, 1);
    smp(16'sh0, 25);
    smp(16'sh200, 1);
    chk("low amp once", 1, ev_cnt[EV_LOW_AMP]);
    a = n_abort;
    smp(16'sh200, 215);
    chk("no cycles", 1, ev_cnt[EV_NO_CYCLES]);
    chk("timeout abort", a + 1, n_abort);
    chk("amp ok", 1, ev_cnt[EV_AMP_OK]);
    fin("slew and timeout");
    // Band changes every sample overrun the tracking limit
    s = n_start;
    smp(-16'sh200, 1);
    smp(16'sh200, 1);
    chk("restart", s + 1, n_start);
    a = n_abort;
    for (int i = 0; i < 22; i++) sample_source_i.put(i[0] ? 16'sh200 : -16'sh200);
    smp(16'sh200, 1);
    chk("overload", 1, ev_cnt[EV_OVERLOAD]);
    chk("ovl abort", a + 1, n_abort);
    for (int i = 0; i < 22; i++) sample_source_i.put(i[0] ? 16'sh200 : -16'sh200);
    smp(16'sh200, 1);
    chk("ovl once", 1, ev_cnt[EV_OVERLOAD]);
    e = ev_cnt[EV_WITHIN];
    s = n_start;
    smp(-16'sh200, 205);
    chk("recover", e + 1, ev_cnt[EV_WITHIN]);
    smp(16'sh200, 1);
    chk("resume", s + 1, n_start);
    fin("overload");
    // Half cycle mode: a falling edge far enough from the start ends the period
    k = n_end;
    wr_reg(OFS_CTRL, 32'h0000_0103);
    smp(16'sh200, 6);
    smp(-16'sh200, 1);
    chk("half end", k + 1, n_end);
    fin("half cycle");
    results();
  end
endmodule
`default_nettype wire
